// ===== bench/bridge_port_command_register_properties.sv
`timescale 1ns/1ns
`default_nettype none
module port_command_checker (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        cfg_wr_i,
    input wire logic        cfg_rd_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic [15:0] cfg_rdata_o,
    input wire logic        io_hit_i,
    input wire logic        mem_hit_i,
    input wire logic        prefetch_hit_i,
    input wire logic        io_claim_o,
    input wire logic        mem_claim_o,
    input wire logic        up_req_valid_i,
    input wire logic        up_req_is_memio_i,
    input wire logic        up_req_nonposted_i,
    input wire logic        up_req_forward_o,
    input wire logic        up_req_ur_o,
    input wire logic        sec_msg_valid_i,
    input wire logic [1:0]  sec_msg_kind_i,
    input wire logic        pri_msg_forward_o,
    input wire logic        own_intx_i,
    input wire logic        own_intx_o
);
    logic [15:0] cmd_r;
    logic [15:0] cmd_nxt;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow of the command register, kept from the configuration writes.
    always_comb begin
        cmd_nxt = cmd_r;
        if (cfg_wr_i && cfg_addr_i == 12'h004) cmd_nxt = cfg_wdata_i & 16'h0547;
    end
    always_ff @(posedge mclk_i) cmd_r <= rst_n_i ? cmd_nxt : 16'h0000;
    sequence s_cmd_read;
        cfg_rd_i && cfg_addr_i == 12'h004;
    endsequence
    sequence s_blocked_req;
        up_req_valid_i && up_req_is_memio_i && !cmd_r[2];
    endsequence
    chk_io_claim: assert property (io_claim_o == (io_hit_i && cmd_r[0]))
        else $error("io claim wrong");
    chk_mem_claim: assert property (mem_claim_o == ((mem_hit_i || prefetch_hit_i) && cmd_r[1]))
        else $error("memory claim wrong");
    chk_blocked_forward: assert property (s_blocked_req |-> !up_req_forward_o)
        else $error("blocked request forwarded");
    chk_ur_answer: assert property (s_blocked_req ##0 up_req_nonposted_i |-> up_req_ur_o)
        else $error("no unsupported answer");
    chk_other_req: assert property (up_req_valid_i && !up_req_is_memio_i |-> up_req_forward_o)
        else $error("other request held");
    chk_err_msg_gate: assert property (sec_msg_valid_i && sec_msg_kind_i inside {2'h1, 2'h2} |-> pri_msg_forward_o == cmd_r[8])
        else $error("error message gating wrong");
    chk_cor_forward: assert property (sec_msg_valid_i && sec_msg_kind_i == 2'h0 |-> pri_msg_forward_o)
        else $error("correctable message held");
    chk_own_intx: assert property (own_intx_o == (own_intx_i && !cmd_r[10]))
        else $error("own interrupt gating wrong");
    chk_read_value: assert property (s_cmd_read |=> cfg_rdata_o == $past(cmd_r))
        else $error("command read value wrong");
endmodule : port_command_checker
bind bridge_port_command_register port_command_checker chk (.*);
`default_nettype wire

// ===== bench/bridge_port_command_register_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bridge_port_command_register_tb;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
    logic [11:0] cfg_addr_i = 12'h000;
    logic [15:0] cfg_wdata_i = 16'h0000, cfg_rdata_o;
    logic io_hit_i = 1'b0, mem_hit_i = 1'b0, prefetch_hit_i = 1'b0;
    logic err_detect_fatal_i = 1'b0, err_detect_nonfatal_i = 1'b0;
    logic devctl_fatal_report_i = 1'b0, devctl_nonfatal_report_i = 1'b0;
    logic up_req_valid_i, up_req_is_memio_i, up_req_nonposted_i, up_cpl_valid_i;
    logic poison_cpl_i, poison_wr_i, sec_msg_valid_i, own_intx_i, fwd_intx_i;
    logic [1:0] sec_msg_kind_i;
    logic io_claim_o, mem_claim_o, up_req_forward_o, up_req_ur_o, up_cpl_forward_o;
    logic err_send_fatal_o, err_send_nonfatal_o, pri_msg_forward_o, own_intx_o, resolved_intx_o;
    logic [10:0] cue = 11'h000, traffic;
    int n_mismatch = 0, n_checks = 0, cycles = 0;
    assign {fwd_intx_i, own_intx_i, sec_msg_kind_i, sec_msg_valid_i, poison_wr_i, poison_cpl_i,
            up_cpl_valid_i, up_req_nonposted_i, up_req_is_memio_i, up_req_valid_i} = traffic;
    bridge_port_command_register dut (.*);
    far_side_model far (.cue_i(cue), .mclk_i(mclk_i), .traffic_o(traffic));
    always #5 mclk_i = ~mclk_i;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic cfg_write(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk_i) #1;
        cfg_wr_i = 1'b1;
        cfg_addr_i = a;
        cfg_wdata_i = d;
        @(posedge mclk_i) #1;
        cfg_wr_i = 1'b0;
    endtask : cfg_write
    task automatic cfg_read(input logic [11:0] a, input logic [15:0] exp, input string what);
        @(posedge mclk_i) #1;
        cfg_rd_i = 1'b1;
        cfg_addr_i = a;
        @(posedge mclk_i) #1;
        cfg_rd_i = 1'b0;
        check(what, exp, cfg_rdata_o);
    endtask : cfg_read
    task automatic far_send(input logic [10:0] c);
        cue = c;
        @(posedge mclk_i) #2;
    endtask : far_send
    initial begin
        repeat (3) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        cfg_read(12'h004, 16'h0000, "command reset");
        io_hit_i = 1'b1;
        prefetch_hit_i = 1'b1;
        #1 check("io claim off", 16'h0000, 16'(io_claim_o));
        check("mem claim off", 16'h0000, 16'(mem_claim_o));
        cfg_write(12'h004, 16'hFFFF);
        cfg_write(12'h00C, 16'h0000);
        cfg_read(12'h004, 16'h0547, "command mask");
        cfg_read(12'h00C, 16'h0000, "unmapped read");
        check("io claim on", 16'h0001, 16'(io_claim_o));
        check("mem claim on", 16'h0001, 16'(mem_claim_o));
        prefetch_hit_i = 1'b0;
        mem_hit_i = 1'b1;
        #1 check("mem window claim", 16'h0001, 16'(mem_claim_o));
        cfg_write(12'h004, 16'h0000);
        check("mem claim dropped", 16'h0000, 16'(mem_claim_o));
        check("io claim dropped", 16'h0000, 16'(io_claim_o));
        far_send(11'h00F);
        check("ur answer", 16'h0001, 16'(up_req_ur_o));
        check("req blocked", 16'h0000, 16'(up_req_forward_o));
        check("cpl passed", 16'h0001, 16'(up_cpl_forward_o));
        far_send(11'h001);
        check("other req", 16'h0001, 16'(up_req_forward_o));
        far_send(11'h030);
        far_send(11'h000);
        cfg_read(12'h006, 16'h0000, "poison ignored");
        cfg_write(12'h004, 16'h0144);
        far_send(11'h010);
        far_send(11'h000);
        cfg_read(12'h006, 16'h0100, "poison status");
        cfg_write(12'h006, 16'h0100);
        cfg_read(12'h006, 16'h0000, "poison cleared");
        far_send(11'h020);
        far_send(11'h000);
        cfg_read(12'h006, 16'h0100, "poison write status");
        cfg_write(12'h006, 16'h0100);
        err_detect_fatal_i = 1'b1;
        @(posedge mclk_i) #1 check("fatal sent", 16'h0001, 16'(err_send_fatal_o));
        err_detect_fatal_i = 1'b0;
        cfg_read(12'h006, 16'h4000, "error status");
        cfg_write(12'h006, 16'h4000);
        cfg_read(12'h006, 16'h0000, "error cleared");
        cfg_write(12'h004, 16'h0000);
        err_detect_fatal_i = 1'b1;
        err_detect_nonfatal_i = 1'b1;
        @(posedge mclk_i) #1 check("fatal held", 16'h0000, 16'(err_send_fatal_o));
        check("nonfatal held", 16'h0000, 16'(err_send_nonfatal_o));
        devctl_fatal_report_i = 1'b1;
        devctl_nonfatal_report_i = 1'b1;
        @(posedge mclk_i) #1 check("fatal devctl", 16'h0001, 16'(err_send_fatal_o));
        check("nonfatal devctl", 16'h0001, 16'(err_send_nonfatal_o));
        err_detect_fatal_i = 1'b0;
        err_detect_nonfatal_i = 1'b0;
        cfg_read(12'h006, 16'h0000, "no error status");
        for (int e = 0; e < 2; e++) begin
            cfg_write(12'h004, e ? 16'h0100 : 16'h0000);
            for (int k = 0; k < 3; k++) begin
                far_send(11'h040 | 11'(k << 7));
                check("message forward", (k == 0) ? 16'h0001 : 16'(e), 16'(pri_msg_forward_o));
            end
        end
        cfg_write(12'h004, 16'h0400);
        far_send(11'h600);
        check("own intx gated", 16'h0000, 16'(own_intx_o));
        check("forwarded intx", 16'h0001, 16'(resolved_intx_o));
        cfg_read(12'h006, 16'h4000, "status intx gated");
        cfg_write(12'h004, 16'h0000);
        check("own intx open", 16'h0001, 16'(own_intx_o));
        cfg_read(12'h006, 16'h4008, "status intx");
        give_verdict();
    end
endmodule : bridge_port_command_register_tb
`default_nettype wire

// ===== bench/far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
    input  wire logic [10:0] cue_i,
    input  wire logic        mclk_i,
    output logic      [10:0] traffic_o
);
    // Traffic from below changes just after the edge, as a registered sender would.
    initial traffic_o = 11'h000;
    always @(posedge mclk_i) traffic_o <= #1 cue_i;
endmodule : far_side_model
`default_nettype wire

// ===== hdl/bridge_port_command_register.sv
// Contract
// - I/O enable bit 0 resets low; when low, primary I/O hits are ignored.
// - Memory enable bit 1 resets low; when low, memory and prefetch hits ignored.
// - Forward enable bit 2 low blocks memory, I/O and MSI requests from below.
// - Forward enable low answers non-posted requests from below with Unsupported Request.
// - Forward enable never affects completions or non memory, non I/O requests.
// - Poison report enable bit 6 lets poisoned completion or write set status.
// - With poison report enable low, the poison status bit is never set.
// - Fatal and non-fatal errors reported when system error enable or device control allow.
// - Fatal and non-fatal messages from below forwarded only with system error enable.
// - Correctable error messages from below are always forwarded.
// - Legacy interrupt disable bit 10 negates the port's own INTx.
// - Legacy interrupt disable does not affect forwarded INTx.
// - Bits 3, 4, 5, 7, 9 and 15:11 are read-only zero.
// - Status bit 8 poison detected is write-one-to-clear.
// - Status bit 14 set on sending fatal or non-fatal with enable; write-one-to-clear.
`timescale 1ns/1ns
`default_nettype none

module bridge_port_command_register (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [11:0] cfg_addr_i,
    input  wire logic [15:0] cfg_wdata_i,
    output logic      [15:0] cfg_rdata_o,
    input  wire logic        io_hit_i,
    input  wire logic        mem_hit_i,
    input  wire logic        prefetch_hit_i,
    output logic             io_claim_o,
    output logic             mem_claim_o,
    input  wire logic        up_req_valid_i,
    input  wire logic        up_req_is_memio_i,
    input  wire logic        up_req_nonposted_i,
    input  wire logic        up_cpl_valid_i,
    output logic             up_req_forward_o,
    output logic             up_req_ur_o,
    output logic             up_cpl_forward_o,
    input  wire logic        poison_cpl_i,
    input  wire logic        poison_wr_i,
    input  wire logic        err_detect_fatal_i,
    input  wire logic        err_detect_nonfatal_i,
    input  wire logic        devctl_fatal_report_i,
    input  wire logic        devctl_nonfatal_report_i,
    output logic             err_send_fatal_o,
    output logic             err_send_nonfatal_o,
    input  wire logic        sec_msg_valid_i,
    input  wire logic [1:0]  sec_msg_kind_i,
    output logic             pri_msg_forward_o,
    input  wire logic        own_intx_i,
    input  wire logic        fwd_intx_i,
    output logic             own_intx_o,
    output logic             resolved_intx_o
);

    cmd_ctrl_if ctrl ();

    // ***************************************************************
    // Command register.
    // ***************************************************************
    logic [15:0] command_r;
    logic [15:0] command_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        cmd_sel;
    logic        sts_sel;
    logic        sts_wr;
    logic        sse_send;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    always_comb begin
        cmd_sel     = addr_is(cfg_addr_i, port_command_pkg::PORT_COMMAND_OFFSET);
        sts_sel     = addr_is(cfg_addr_i, port_command_pkg::PORT_STATUS_OFFSET);
        sts_wr      = cfg_wr_i & sts_sel;
        command_nxt = command_r;
        if (cfg_wr_i && cmd_sel) begin
            command_nxt = cfg_wdata_i & port_command_pkg::PORT_COMMAND_WMASK;
        end
        rdata_nxt = rdata_r;
        if (cfg_rd_i) begin
            if (cmd_sel) begin
                rdata_nxt = command_r;
            end else if (sts_sel) begin
                rdata_nxt = ctrl.status;
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            command_r <= port_command_pkg::PORT_COMMAND_RESET;
            rdata_r   <= 16'h0000;
        end else begin
            command_r <= command_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign ctrl.command = command_r;
    assign cfg_rdata_o  = rdata_r;

    // ***************************************************************
    // Decode, forwarding, error and interrupt gating.
    // ***************************************************************
    logic io_en;
    logic mem_en;
    logic fwd_en;
    logic serr_en;
    logic intx_dis;
    logic sec_fatal;

    always_comb begin
        io_en    = command_r[port_command_pkg::IO_SPACE_ENABLE_BIT];
        mem_en   = command_r[port_command_pkg::MEMORY_SPACE_ENABLE_BIT];
        fwd_en   = command_r[port_command_pkg::REQUEST_FORWARD_ENABLE_BIT];
        serr_en  = command_r[port_command_pkg::SYSTEM_ERROR_ENABLE_BIT];
        intx_dis = command_r[port_command_pkg::LEGACY_IRQ_DISABLE_BIT];
        io_claim_o  = io_en & io_hit_i;
        mem_claim_o = mem_en & (mem_hit_i | prefetch_hit_i);
        up_req_forward_o = up_req_valid_i & (fwd_en | ~up_req_is_memio_i);
        up_req_ur_o = up_req_valid_i & up_req_is_memio_i & ~fwd_en
                      & up_req_nonposted_i;
        up_cpl_forward_o = up_cpl_valid_i;
        err_send_fatal_o    = err_detect_fatal_i & (serr_en | devctl_fatal_report_i);
        err_send_nonfatal_o = err_detect_nonfatal_i & (serr_en | devctl_nonfatal_report_i);
        sec_fatal = (sec_msg_kind_i == port_command_pkg::MSG_ERR_FATAL)
                    | (sec_msg_kind_i == port_command_pkg::MSG_ERR_NONFATAL);
        pri_msg_forward_o = sec_msg_valid_i
                            & (sec_fatal ? serr_en : 1'b1);
        own_intx_o      = own_intx_i & ~intx_dis;
        resolved_intx_o = own_intx_o | fwd_intx_i;
        sse_send = (err_send_fatal_o | err_send_nonfatal_o)
                   | (sec_msg_valid_i & sec_fatal & serr_en);
    end

    port_status_bits u_status (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .ctrl        (ctrl.user),
        .sts_wr_i    (sts_wr),
        .sts_wdata_i (cfg_wdata_i),
        .poison_cpl_i(poison_cpl_i),
        .poison_wr_i (poison_wr_i),
        .err_sent_i  (sse_send),
        .intx_pend_i (own_intx_o)
    );

endmodule : bridge_port_command_register

`default_nettype wire

// ===== hdl/cmd_ctrl_if.sv
`timescale 1ns/1ns
`default_nettype none

interface cmd_ctrl_if;
    logic [15:0] command;
    logic [15:0] status;

    modport owner (
        output command,
        input  status
    );
    modport user (
        input  command,
        output status
    );
endinterface : cmd_ctrl_if

`default_nettype wire

// ===== hdl/port_command_pkg.sv
`default_nettype none
package port_command_pkg;

    localparam logic [11:0] PORT_COMMAND_OFFSET = 12'h004;
    localparam logic [11:0] PORT_STATUS_OFFSET  = 12'h006;

    localparam logic [15:0] PORT_COMMAND_RESET  = 16'h0000;
    localparam logic [15:0] PORT_COMMAND_WMASK  = 16'h0547;

    localparam int IO_SPACE_ENABLE_BIT       = 0;
    localparam int MEMORY_SPACE_ENABLE_BIT   = 1;
    localparam int REQUEST_FORWARD_ENABLE_BIT = 2;
    localparam int POISON_REPORT_ENABLE_BIT  = 6;
    localparam int SYSTEM_ERROR_ENABLE_BIT   = 8;
    localparam int LEGACY_IRQ_DISABLE_BIT    = 10;

    localparam int INTX_STATUS_BIT           = 3;
    localparam int POISON_DETECTED_BIT       = 8;
    localparam int SYSTEM_ERROR_SIGNALLED_BIT = 14;

    localparam logic [15:0] PORT_STATUS_RESET = 16'h0000;

    typedef enum logic [1:0] {
        MSG_ERR_COR,
        MSG_ERR_NONFATAL,
        MSG_ERR_FATAL,
        MSG_OTHER
    } err_msg_type;

endpackage : port_command_pkg
`default_nettype wire

// ===== hdl/port_status_bits.sv
`timescale 1ns/1ns
`default_nettype none

module port_status_bits (
    input  wire logic  mclk_i,
    input  wire logic  rst_n_i,
    cmd_ctrl_if.user   ctrl,
    input  wire logic  sts_wr_i,
    input  wire logic [15:0] sts_wdata_i,
    input  wire logic  poison_cpl_i,
    input  wire logic  poison_wr_i,
    input  wire logic  err_sent_i,
    input  wire logic  intx_pend_i
);

    // ***************************************************************
    // Sticky status flags; a new event wins over a clear.
    // ***************************************************************
    logic mdpd_r;
    logic mdpd_nxt;
    logic sse_r;
    logic sse_nxt;
    logic poison_ev;
    logic serr_ev;

    always_comb begin
        poison_ev = ctrl.command[port_command_pkg::POISON_REPORT_ENABLE_BIT]
                    & (poison_cpl_i | poison_wr_i);
        serr_ev   = ctrl.command[port_command_pkg::SYSTEM_ERROR_ENABLE_BIT] & err_sent_i;
        mdpd_nxt  = mdpd_r;
        sse_nxt   = sse_r;
        if (sts_wr_i && sts_wdata_i[port_command_pkg::POISON_DETECTED_BIT]) begin
            mdpd_nxt = 1'b0;
        end
        if (sts_wr_i && sts_wdata_i[port_command_pkg::SYSTEM_ERROR_SIGNALLED_BIT]) begin
            sse_nxt = 1'b0;
        end
        if (poison_ev) begin
            mdpd_nxt = 1'b1;
        end
        if (serr_ev) begin
            sse_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mdpd_r <= 1'b0;
            sse_r  <= 1'b0;
        end else begin
            mdpd_r <= mdpd_nxt;
            sse_r  <= sse_nxt;
        end
    end

    always_comb begin
        ctrl.status = port_command_pkg::PORT_STATUS_RESET;
        ctrl.status[port_command_pkg::POISON_DETECTED_BIT]        = mdpd_r;
        ctrl.status[port_command_pkg::SYSTEM_ERROR_SIGNALLED_BIT] = sse_r;
        ctrl.status[port_command_pkg::INTX_STATUS_BIT]            = intx_pend_i;
    end

endmodule : port_status_bits

`default_nettype wire
